/* File: design/tbnrd_pkg.sv */
// Constants and register map of the token-bus node reset and diagnostics block
package tbnrd_pkg;
  // Clock and reset glitch filter
  localparam int CLK_PERIOD_PS = 8000;
  localparam int HW_RST_MIN_PS = 3200000;
  localparam int HW_RST_CYC = (HW_RST_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int HW_RST_CW = 9;

  // Word offsets on the bus (byte addresses)
  localparam logic [5:0] OFS_CONFIG = 6'h00;
  localparam logic [5:0] OFS_SETUP = 6'h04;
  localparam logic [5:0] OFS_NODE_ID = 6'h08;
  localparam logic [5:0] OFS_PROBE_ID = 6'h0c;
  localparam logic [5:0] OFS_NEXT_ID = 6'h10;
  localparam logic [5:0] OFS_DIAG = 6'h14;
  localparam logic [5:0] OFS_STATUS = 6'h18;
  localparam logic [5:0] OFS_IMR = 6'h1c;
  localparam logic [5:0] OFS_CMD = 6'h20;

  // Configuration bits
  localparam int CFG_SOFT_RESET = 7;
  localparam int CFG_JOIN_EN = 5;
  // Setup bits
  localparam int SET_SHORT_LIMIT = 0;
  localparam int SET_EXT_ONE = 1;
  localparam int SET_EXT_TWO = 2;
  // Diagnostic status bits
  localparam int DG_SELF_REBUILD = 7;
  localparam int DG_DUPLICATE = 6;
  localparam int DG_LINE_ACT = 5;
  localparam int DG_FOREIGN = 4;
  localparam int DG_EXCESS = 3;
  localparam int DG_NEXT_CHG = 2;
  localparam int DG_PROBE = 1;
  // Status bits (interrupt sources gated by the mask)
  localparam int ST_XMIT_IDLE = 0;
  localparam int ST_EXCESS = 1;
  localparam int ST_RING_REBUILD = 2;
  localparam int ST_NEXT_CHG = 3;

  // Command codes written to the command register
  localparam logic [7:0] CMD_DISABLE_TX = 8'h01;
  localparam logic [7:0] CMD_CLEAR_FLAGS = 8'h02;
  localparam logic [7:0] CMD_ENABLE_TX = 8'h03;

  // Reset values
  localparam logic [7:0] RST_CONFIG = 8'h00;
  localparam logic [7:0] RST_SETUP = 8'h00;
  localparam logic [7:0] RST_IMR = 8'h00;
  localparam logic [7:0] RST_NODE_ID = 8'h00;
  localparam logic [7:0] RST_NEXT_ID = 8'h00;

  // Buffer RAM check pattern written at wake-up
  localparam logic [7:0] CHECK_PATTERN = 8'hd1;
  localparam logic [8:0] RAM_ADDR_PAT = 9'h000;
  localparam logic [8:0] RAM_ADDR_ID = 9'h001;

  // Refusal limits
  localparam logic [6:0] REFUSE_LONG_LAST = 7'h7f;
  localparam logic [6:0] REFUSE_SHORT_LAST = 7'h03;

  typedef enum logic [1:0] {TBNRD_RAM_IDLE, TBNRD_RAM_PAT, TBNRD_RAM_ID} tbnrd_ram_t;
endpackage

/* File: design/tbnrd_core.sv */
// Reset, wake-up, initialization and network diagnostics of a token-bus node core
`timescale 1ns/100ps
module tbnrd_core
  import tbnrd_pkg::*;
(
  input wire logic clk_i, // Core clock, 125 MHz
  input wire logic rstn_i, // Power-on reset, async, active low
  input wire logic hw_reset_i, // Reset pin, active high, unfiltered
  input wire logic line_receive_input, // Receive line pin
  // Wishbone slave
  input wire logic wb_cyc_i, // Bus cycle
  input wire logic wb_stb_i, // Strobe
  input wire logic wb_we_i, // Write enable
  input wire logic [5:0] wb_adr_i, // Byte address
  input wire logic [3:0] wb_sel_i, // Byte lanes
  input wire logic [31:0] wb_dat_i, // Write data
  output logic [31:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Acknowledge
  // Events from the line engine, same clock
  input wire logic tok_seen_i, // Token observed on the line, pulse
  input wire logic [7:0] tok_did_i, // Destination of observed token
  input wire logic tok_own_i, // Observed token was sent by this node
  input wire logic tok_resp_i, // Response to last observed token, pulse
  input wire logic tok_rcv_i, // This node received the token, pulse
  input wire logic ring_rebuild_flag_start_i, // Own token timer expired, pulse
  input wire logic net_ring_rebuild_flag_i, // Any reconfiguration seen, pulse
  input wire logic fbe_nak_i, // Free-buffer enquiry refused, pulse
  input wire logic fbe_ack_i, // Free-buffer enquiry accepted, pulse
  input wire logic succ_valid_i, // Successor identifier update, pulse
  input wire logic [7:0] succ_id_i, // New successor identifier
  // Core controls
  output logic core_reset_o, // Core held in reset
  output logic core_run_o, // Microcode may run
  output logic join_en_o, // Node may join and pass tokens
  output logic tx_drive_o, // Transmitter enabled
  output logic xmit_abort_o, // Abandon pending transmission, pulse
  output logic ram_we_o, // Buffer RAM write strobe
  output logic [8:0] ram_addr_o, // Buffer RAM address
  output logic [7:0] ram_data_o, // Buffer RAM data
  output logic host_irq_o // Interrupt to host, active high
);

  // Synchronisers for the two pins
  logic rst_meta;
  logic rst_sync;
  logic rx_meta;
  logic rx_sync;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
      rx_meta <= 1'b0;
      rx_sync <= 1'b0;
    end else begin
      rst_meta <= hw_reset_i;
      rst_sync <= rst_meta;
      rx_meta <= line_receive_input;
      rx_sync <= rx_meta;
    end
  end

  // Glitch filter: reset only after the level held for the full count
  logic [HW_RST_CW-1:0] filt_cnt;
  logic hw_rst;
  wire filt_full = (filt_cnt == HW_RST_CW'(HW_RST_CYC - 1));

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      filt_cnt <= '0;
      hw_rst <= 1'b0;
    end else if (!rst_sync) begin
      filt_cnt <= '0;
      hw_rst <= 1'b0;
    end else if (filt_full) begin
      hw_rst <= 1'b1;
    end else begin
      filt_cnt <= filt_cnt + HW_RST_CW'(1);
    end
  end

  // Registers
  logic [7:0] cfg_reg;
  logic [7:0] setup_reg;
  logic [7:0] imr_reg;
  logic [7:0] node_id_register;
  logic [7:0] probe_id;
  logic [7:0] next_id;
  logic self_rebuild_flag;
  logic duplicate_address_flag;
  logic line_activity_flag;
  logic foreign_pass_flag;
  logic excess_refusal_flag;
  logic next_changed_flag;
  logic probe_match_flag;
  logic ring_rebuild_flag;
  logic xmit_idle_flag;
  logic own_pending;
  logic probe_pending;
  logic [6:0] refuse_cnt;

  wire soft_rst = cfg_reg[CFG_SOFT_RESET];
  wire any_rst = soft_rst | hw_rst;
  wire awake = (node_id_register != 8'h00) & ~any_rst;
  wire joined = awake & cfg_reg[CFG_JOIN_EN];

  // Bus decode; an access is taken on the edge that raises ack
  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr = req & wb_we_i & wb_sel_i[0];
  wire rd = req & ~wb_we_i;
  wire wr_cfg = wr & (wb_adr_i == OFS_CONFIG);
  wire wr_setup = wr & (wb_adr_i == OFS_SETUP);
  wire wr_node = wr & (wb_adr_i == OFS_NODE_ID);
  wire wr_probe = wr & (wb_adr_i == OFS_PROBE_ID);
  wire wr_imr = wr & (wb_adr_i == OFS_IMR);
  wire wr_cmd = wr & (wb_adr_i == OFS_CMD);
  wire rd_diag = rd & (wb_adr_i == OFS_DIAG);
  wire [7:0] wdat = wb_dat_i[7:0];
  wire cmd_dis_tx = wr_cmd & (wdat == CMD_DISABLE_TX);
  wire cmd_clr = wr_cmd & (wdat == CMD_CLEAR_FLAGS);
  wire cmd_en_tx = wr_cmd & (wdat == CMD_ENABLE_TX);

  // Network events qualified by the wake state
  wire foreign_tok = awake & tok_seen_i & ~tok_own_i;
  wire own_match = foreign_tok & (tok_did_i == node_id_register);
  wire probe_hit = foreign_tok & (tok_did_i == probe_id);
  wire dup_set = awake & tok_resp_i & (own_pending | own_match);
  wire probe_set = awake & tok_resp_i & (probe_pending | probe_hit);
  wire self_set = joined & ring_rebuild_flag_start_i;
  wire ring_set = awake & (net_ring_rebuild_flag_i | self_set);
  wire succ_chg = awake & succ_valid_i & (succ_id_i != next_id);
  wire [6:0] refuse_last = setup_reg[SET_SHORT_LIMIT] ? REFUSE_SHORT_LAST
                                                       : REFUSE_LONG_LAST;
  wire refuse_wrap = joined & fbe_nak_i & (refuse_cnt == refuse_last);

  wire [7:0] diag_val = {self_rebuild_flag, duplicate_address_flag, line_activity_flag,
                         foreign_pass_flag, excess_refusal_flag, next_changed_flag,
                         probe_match_flag, 1'b0};
  wire [7:0] stat_val = {4'h0, next_changed_flag, ring_rebuild_flag,
                         excess_refusal_flag, xmit_idle_flag};
  logic [7:0] rd_mux;

  always_comb begin
    case (wb_adr_i)
      OFS_CONFIG: rd_mux = cfg_reg;
      OFS_SETUP: rd_mux = setup_reg;
      OFS_NODE_ID: rd_mux = node_id_register;
      OFS_PROBE_ID: rd_mux = probe_id;
      OFS_NEXT_ID: rd_mux = next_id;
      OFS_DIAG: rd_mux = diag_val;
      OFS_STATUS: rd_mux = stat_val;
      OFS_IMR: rd_mux = imr_reg;
      default: rd_mux = 8'h00;
    endcase
  end

  // Bus answer: one wait state, ack for exactly one cycle, unmapped reads zero
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      if (rd) begin
        wb_dat_o <= {24'h00_0000, rd_mux};
      end
    end
  end

  // Registers that survive software reset; only the filtered pin and the power-on reset clear them
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg_reg <= RST_CONFIG;
      setup_reg <= RST_SETUP;
      imr_reg <= RST_IMR;
    end else if (hw_rst) begin
      cfg_reg <= RST_CONFIG;
      setup_reg <= RST_SETUP;
      imr_reg <= RST_IMR;
    end else begin
      if (wr_cfg) cfg_reg <= wdat;
      if (wr_setup) setup_reg <= wdat;
      if (wr_imr) imr_reg <= wdat;
    end
  end

  // Identifiers and successor
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      node_id_register <= RST_NODE_ID;
      probe_id <= RST_NODE_ID;
      next_id <= RST_NEXT_ID;
    end else if (any_rst) begin
      node_id_register <= RST_NODE_ID;
      probe_id <= RST_NODE_ID;
      next_id <= RST_NEXT_ID;
    end else begin
      if (wr_node) node_id_register <= wdat;
      if (wr_probe) probe_id <= wdat;
      if (succ_chg) next_id <= succ_id_i;
    end
  end

  // Pending token matches, closed by a response or by the next token on the line
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      own_pending <= 1'b0;
      probe_pending <= 1'b0;
    end else if (any_rst || wr_node || wr_probe) begin
      own_pending <= 1'b0;
      probe_pending <= 1'b0;
    end else if (tok_seen_i) begin
      own_pending <= own_match & ~tok_resp_i;
      probe_pending <= probe_hit & ~tok_resp_i;
    end else if (tok_resp_i) begin
      own_pending <= 1'b0;
      probe_pending <= 1'b0;
    end
  end

  // Diagnostic flags: an event in the clearing cycle wins over the clear
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      self_rebuild_flag <= 1'b0;
      duplicate_address_flag <= 1'b0;
      line_activity_flag <= 1'b0;
      foreign_pass_flag <= 1'b0;
      next_changed_flag <= 1'b0;
      probe_match_flag <= 1'b0;
    end else if (any_rst) begin
      self_rebuild_flag <= 1'b0;
      duplicate_address_flag <= 1'b0;
      line_activity_flag <= 1'b0;
      foreign_pass_flag <= 1'b0;
      next_changed_flag <= 1'b0;
      probe_match_flag <= 1'b0;
    end else begin
      if (self_set) self_rebuild_flag <= 1'b1;
      else if (rd_diag) self_rebuild_flag <= 1'b0;
      if (dup_set) duplicate_address_flag <= 1'b1;
      else if (rd_diag) duplicate_address_flag <= 1'b0;
      if (rx_sync) line_activity_flag <= 1'b1;
      else if (rd_diag) line_activity_flag <= 1'b0;
      if (foreign_tok) foreign_pass_flag <= 1'b1;
      else if (rd_diag) foreign_pass_flag <= 1'b0;
      if (succ_chg) next_changed_flag <= 1'b1;
      else if (rd_diag) next_changed_flag <= 1'b0;
      if (probe_set) probe_match_flag <= 1'b1;
      else if (rd_diag || wr_probe) probe_match_flag <= 1'b0;
    end
  end

  // Refusal counter wraps so the flag can fire again after clearing
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      refuse_cnt <= 7'h00;
      excess_refusal_flag <= 1'b0;
      ring_rebuild_flag <= 1'b0;
    end else if (any_rst) begin
      refuse_cnt <= 7'h00;
      excess_refusal_flag <= 1'b0;
      ring_rebuild_flag <= 1'b0;
    end else begin
      if (fbe_ack_i || cmd_dis_tx) begin
        refuse_cnt <= 7'h00;
      end else if (refuse_wrap) begin
        refuse_cnt <= 7'h00;
      end else if (joined && fbe_nak_i) begin
        refuse_cnt <= refuse_cnt + 7'h01;
      end
      if (refuse_wrap) excess_refusal_flag <= 1'b1;
      else if (cmd_clr) excess_refusal_flag <= 1'b0;
      if (ring_set) ring_rebuild_flag <= 1'b1;
      else if (cmd_clr) ring_rebuild_flag <= 1'b0;
    end
  end

  // Transmit availability: abandon now, report idle at the next token
  logic abandon_wait;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      xmit_idle_flag <= 1'b1;
      abandon_wait <= 1'b0;
      xmit_abort_o <= 1'b0;
    end else if (any_rst) begin
      xmit_idle_flag <= 1'b1;
      abandon_wait <= 1'b0;
      xmit_abort_o <= 1'b0;
    end else begin
      xmit_abort_o <= cmd_dis_tx;
      if (cmd_en_tx) begin
        xmit_idle_flag <= 1'b0;
        abandon_wait <= 1'b0;
      end else if (cmd_dis_tx) begin
        abandon_wait <= 1'b1;
      end else if (abandon_wait && tok_rcv_i) begin
        xmit_idle_flag <= 1'b1;
        abandon_wait <= 1'b0;
      end
    end
  end

  // Wake-up check writes into buffer RAM
  tbnrd_ram_t ram_st;
  tbnrd_ram_t next_ram_st;

  always_comb begin
    case (ram_st)
      TBNRD_RAM_IDLE: next_ram_st = wr_node ? TBNRD_RAM_PAT : TBNRD_RAM_IDLE;
      TBNRD_RAM_PAT: next_ram_st = TBNRD_RAM_ID;
      TBNRD_RAM_ID: next_ram_st = wr_node ? TBNRD_RAM_PAT : TBNRD_RAM_IDLE;
      default: next_ram_st = TBNRD_RAM_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ram_st <= TBNRD_RAM_IDLE;
      ram_we_o <= 1'b0;
      ram_addr_o <= RAM_ADDR_PAT;
      ram_data_o <= 8'h00;
    end else if (any_rst) begin
      ram_st <= TBNRD_RAM_IDLE;
      ram_we_o <= 1'b0;
    end else begin
      ram_st <= next_ram_st;
      ram_we_o <= (next_ram_st != TBNRD_RAM_IDLE);
      if (next_ram_st == TBNRD_RAM_PAT) begin
        ram_addr_o <= RAM_ADDR_PAT;
        ram_data_o <= CHECK_PATTERN;
      end else if (next_ram_st == TBNRD_RAM_ID) begin
        ram_addr_o <= RAM_ADDR_ID;
        ram_data_o <= node_id_register;
      end
    end
  end

  // Registered control and interrupt outputs
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      core_reset_o <= 1'b1;
      core_run_o <= 1'b0;
      join_en_o <= 1'b0;
      tx_drive_o <= 1'b0;
      host_irq_o <= 1'b0;
    end else begin
      core_reset_o <= any_rst;
      core_run_o <= awake;
      join_en_o <= joined;
      tx_drive_o <= joined & ~abandon_wait;
      host_irq_o <= |(stat_val & imr_reg);
    end
  end

endmodule

/* File: testbench/tbnrd_core_chk.sv */
// Port-level checks of the token-bus node reset and diagnostics block
`timescale 1ns/100ps
module tbnrd_core_chk
  import tbnrd_pkg::*;
(
  input wire logic clk_i, // clock
  input wire logic rstn_i, // reset, low
  input wire logic hw_reset_i, // reset pin
  input wire logic wb_cyc_i, // cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_we_i, // write
  input wire logic [5:0] wb_adr_i, // address
  input wire logic [3:0] wb_sel_i, // lanes
  input wire logic [31:0] wb_dat_i, // write data
  input wire logic wb_ack_o, // ack
  input wire logic core_reset_o, // in reset
  input wire logic core_run_o, // awake
  input wire logic join_en_o, // joined
  input wire logic tx_drive_o, // transmitter
  input wire logic xmit_abort_o, // abandon
  input wire logic ram_we_o, // ram strobe
  input wire logic [8:0] ram_addr_o, // ram address
  input wire logic [7:0] ram_data_o // ram data
);
  logic [8:0] hw_cnt;
  logic soft_q;
  wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wr_take = take && wb_we_i && wb_sel_i[0] && !core_reset_o;
  wire cfg_wr = take && wb_we_i && wb_sel_i[0] && wb_adr_i == OFS_CONFIG;
  wire id_wr = wr_take && wb_adr_i == OFS_NODE_ID && wb_dat_i[7:0] != 8'h00;
  wire abort_wr = wr_take && wb_adr_i == OFS_CMD && wb_dat_i[7:0] == CMD_DISABLE_TX;
  wire hw_long = hw_cnt >= HW_RST_CYC;

  // Pin-high counter saturates so a long reset never looks short again
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hw_cnt <= 9'h000;
      soft_q <= 1'b0;
    end else begin
      hw_cnt <= !hw_reset_i ? 9'h000 : (hw_cnt == 9'h1ff ? hw_cnt : hw_cnt + 9'h001);
      soft_q <= hw_long ? 1'b0 : (cfg_wr ? wb_dat_i[CFG_SOFT_RESET] : soft_q);
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);

  a_ack_next: assert property (take |=> wb_ack_o)
    else $error("bus request not acknowledged next cycle");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");
  a_ram_seq: assert property (
    id_wr |=> ram_we_o && ram_addr_o == RAM_ADDR_PAT && ram_data_o == CHECK_PATTERN
    ##1 ram_we_o && ram_addr_o == RAM_ADDR_ID && ram_data_o == $past(wb_dat_i[7:0], 2)
    ##1 !ram_we_o)
    else $error("wake-up buffer writes wrong");
  a_soft_enter: assert property (cfg_wr && wb_dat_i[CFG_SOFT_RESET] |-> ##[1:2] core_reset_o)
    else $error("soft reset not entered");
  a_soft_hold: assert property (soft_q && $past(soft_q, 2) |-> core_reset_o)
    else $error("soft reset left while bit set");
  a_hw_filter: assert property ($rose(core_reset_o) |-> hw_long || soft_q || $past(soft_q))
    else $error("reset taken from a short pin pulse");
  a_reset_quiet: assert property (core_reset_o |=> !core_run_o && !join_en_o && !tx_drive_o)
    else $error("core active during reset");
  a_join_gate: assert property (join_en_o |-> core_run_o)
    else $error("joined while asleep");
  a_abort_pulse: assert property (abort_wr |-> ##[1:2] (xmit_abort_o ##1 !xmit_abort_o))
    else $error("abandon pulse missing");
  a_abort_quiet: assert property (xmit_abort_o |-> ##[0:2] !tx_drive_o)
    else $error("transmitter still driving after abandon");
endmodule

/* File: testbench/tbnrd_net.sv */
// Model of the other nodes on the medium, seen through line-engine events
`timescale 1ns/100ps
module tbnrd_net (
  input wire logic clk_i, // clock
  output logic line_o, // receive line
  output logic seen_o, // token seen
  output logic [7:0] did_o, // destination
  output logic own_o, // our own token
  output logic resp_o, // response
  output logic [4:0] ev_o, // rcv, timer, ring_rebuild_flag, nak, accept
  output logic sv_o, // successor update
  output logic [7:0] sid_o // successor id
);
  initial begin
    {line_o, seen_o, own_o, resp_o, sv_o, ev_o, did_o, sid_o} = {10'h000, 16'h5aa5};
  end

  // Stale fields get the inverse so a late sample cannot pass by luck
  task automatic token(input logic [7:0] did, input logic own, input logic resp);
    @(posedge clk_i);
    {seen_o, own_o, resp_o, did_o} <= {1'b1, own, resp, did};
    @(posedge clk_i);
    {seen_o, own_o, resp_o, did_o} <= {3'b000, ~did};
  endtask

  task automatic pulse(input int k, input int n);
    repeat (n) begin
      @(posedge clk_i);
      ev_o[k] <= 1'b1;
      @(posedge clk_i);
      ev_o[k] <= 1'b0;
    end
  endtask

  task automatic succ(input logic [7:0] id);
    @(posedge clk_i);
    {sv_o, sid_o} <= {1'b1, id};
    @(posedge clk_i);
    {sv_o, sid_o} <= {1'b0, ~id};
  endtask

  task automatic level(input logic v);
    @(posedge clk_i);
    line_o <= v;
    repeat (3) @(posedge clk_i);
  endtask
endmodule

/* File: testbench/tbnrd_core_tb.sv */
// Self-checking bench of the token-bus node reset and diagnostics block
`timescale 1ns/100ps
module tbnrd_core_tb;
  import tbnrd_pkg::*;
  logic clk_i = 1'b0, rstn_i = 1'b0, hw_reset_i = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [5:0] wb_adr_i = 6'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, core_reset_o, core_run_o, join_en_o, tx_drive_o, xmit_abort_o, ram_we_o;
  logic host_irq_o, line, seen, own, resp, sv;
  logic [8:0] ram_addr_o;
  logic [7:0] ram_data_o, did, sid, id, oth, prb;
  logic [4:0] ev;
  logic [31:0] rd_q[$];
  logic [16:0] ram_q[$];
  int errors = 0, checks_done = 0, lim;

  always #4 clk_i = ~clk_i;

  tbnrd_net net_u (.clk_i(clk_i), .line_o(line), .seen_o(seen), .did_o(did), .own_o(own),
    .resp_o(resp), .ev_o(ev), .sv_o(sv), .sid_o(sid));

  tbnrd_core dut_u (.clk_i(clk_i), .rstn_i(rstn_i), .hw_reset_i(hw_reset_i),
    .line_receive_input(line), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .tok_seen_i(seen), .tok_did_i(did), .tok_own_i(own),
    .tok_resp_i(resp), .tok_rcv_i(ev[0]), .ring_rebuild_flag_start_i(ev[1]), .net_ring_rebuild_flag_i(ev[2]),
    .fbe_nak_i(ev[3]), .fbe_ack_i(ev[4]), .succ_valid_i(sv), .succ_id_i(sid),
    .core_reset_o(core_reset_o), .core_run_o(core_run_o), .join_en_o(join_en_o),
    .tx_drive_o(tx_drive_o), .xmit_abort_o(xmit_abort_o), .ram_we_o(ram_we_o),
    .ram_addr_o(ram_addr_o), .ram_data_o(ram_data_o), .host_irq_o(host_irq_o));

  task automatic chk(input logic [31:0] seen_v, input logic [31:0] exp);
    checks_done++;
    if (seen_v !== exp) begin
      errors++;
      $display("Error at %0t: saw %h, expected %h", $time, seen_v, exp);
    end
  endtask

  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Request held until ack is sampled high; a missing ack is counted, not waited on forever
  task automatic bus(input logic we, input logic [5:0] adr, input logic [7:0] dat);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, adr, 24'h0, dat};
    @(posedge clk_i);
    for (int i = 0; i < 16 && wb_ack_o !== 1'b1; i++) @(posedge clk_i);
    if (wb_ack_o !== 1'b1) chk(wb_ack_o, 1'b1);
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask

  task automatic wr(input logic [5:0] adr, input logic [7:0] dat);
    bus(1'b1, adr, dat);
  endtask

  task automatic rd(input logic [5:0] adr, input logic [7:0] exp);
    rd_q.push_back({24'h0, exp});
    bus(1'b0, adr, 8'h00);
  endtask

  task automatic settle;
    repeat (3) @(posedge clk_i);
  endtask

  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) chk(wb_dat_o, rd_q.pop_front());
    if (ram_we_o === 1'b1) chk({ram_addr_o, ram_data_o}, ram_q.pop_front());
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    give_verdict;
  end

  initial begin
    void'($urandom(47389));
    id = 8'($urandom_range(127, 1));
    oth = id ^ 8'h80;
    prb = oth ^ 8'h01;
    repeat (8) @(posedge clk_i);
    rstn_i <= 1'b1;
    rd(OFS_CONFIG, RST_CONFIG);
    rd(OFS_SETUP, RST_SETUP);
    rd(OFS_NODE_ID, RST_NODE_ID);
    rd(OFS_NEXT_ID, RST_NEXT_ID);
    rd(OFS_IMR, RST_IMR);
    rd(6'h24, 8'h00);
    // Asleep: only the line level is flagged, token and reconfiguration are ignored
    net_u.level(1'b1);
    net_u.token(oth, 1'b0, 1'b1);
    net_u.pulse(2, 1);
    net_u.level(1'b0);
    rd(OFS_DIAG, 8'h20);
    rd(OFS_STATUS, 8'h01);
    chk(core_run_o, 1'b0);
    wr(OFS_SETUP, 8'h00);
    ram_q.push_back({RAM_ADDR_PAT, CHECK_PATTERN});
    ram_q.push_back({RAM_ADDR_ID, id});
    wr(OFS_NODE_ID, id);
    settle;
    chk(core_run_o, 1'b1);
    chk(join_en_o, 1'b0);
    chk(ram_q.size(), 0);
    net_u.token(oth, 1'b1, 1'b0);
    rd(OFS_DIAG, 8'h00);
    net_u.level(1'b1);
    net_u.level(1'b0);
    rd(OFS_DIAG, 8'h20);
    net_u.token(oth, 1'b0, 1'b0);
    rd(OFS_DIAG, 8'h10);
    net_u.token(id, 1'b0, 1'b1);
    rd(OFS_DIAG, 8'h50);
    rd(OFS_DIAG, 8'h00);
    wr(OFS_PROBE_ID, prb);
    net_u.token(prb, 1'b0, 1'b1);
    rd(OFS_DIAG, 8'h12);
    wr(OFS_CONFIG, 8'h20);
    settle;
    chk({join_en_o, tx_drive_o}, 2'b11);
    net_u.pulse(1, 1);
    rd(OFS_DIAG, 8'h80);
    rd(OFS_DIAG, 8'h00);
    wr(OFS_IMR, 8'h04);
    wr(OFS_CMD, CMD_CLEAR_FLAGS);
    net_u.pulse(2, 1);
    rd(OFS_STATUS, 8'h05);
    chk(host_irq_o, 1'b1);
    wr(OFS_CMD, CMD_CLEAR_FLAGS);
    rd(OFS_STATUS, 8'h01);
    chk(host_irq_o, 1'b0);
    wr(OFS_IMR, 8'h02);
    // Long limit first, then the short one; the wrapped count starts each at zero
    for (int k = 0; k < 2; k++) begin
      lim = (k == 0) ? 128 : 4;
      wr(OFS_SETUP, {7'h00, k[0]});
      net_u.pulse(3, 2);
      net_u.pulse(4, 1);
      net_u.pulse(3, lim - 1);
      rd(OFS_STATUS, 8'h01);
      net_u.pulse(3, 1);
      rd(OFS_STATUS, 8'h03);
      chk(host_irq_o, 1'b1);
      wr(OFS_CMD, CMD_CLEAR_FLAGS);
      rd(OFS_STATUS, 8'h01);
      net_u.pulse(3, lim);
      rd(OFS_STATUS, 8'h03);
      wr(OFS_CMD, CMD_CLEAR_FLAGS);
    end
    wr(OFS_CMD, CMD_ENABLE_TX);
    wr(OFS_CMD, CMD_DISABLE_TX);
    settle;
    chk(tx_drive_o, 1'b0);
    rd(OFS_STATUS, 8'h00);
    net_u.pulse(0, 1);
    rd(OFS_STATUS, 8'h01);
    net_u.succ(prb);
    rd(OFS_NEXT_ID, prb);
    rd(OFS_DIAG, 8'h04);
    wr(OFS_IMR, 8'h0c);
    wr(OFS_SETUP, 8'h06);
    wr(OFS_CONFIG, 8'ha0);
    repeat (20) @(posedge clk_i);
    chk({core_reset_o, tx_drive_o}, 2'b10);
    rd(OFS_CONFIG, 8'ha0);
    rd(OFS_SETUP, 8'h06);
    rd(OFS_IMR, 8'h0c);
    rd(OFS_NODE_ID, 8'h00);
    rd(OFS_NEXT_ID, 8'h00);
    wr(OFS_CONFIG, 8'h00);
    settle;
    chk({core_reset_o, core_run_o}, 2'b00);
    hw_reset_i <= 1'b1;
    repeat (300) @(posedge clk_i);
    hw_reset_i <= 1'b0;
    chk(core_reset_o, 1'b0);
    rd(OFS_SETUP, 8'h06);
    hw_reset_i <= 1'b1;
    repeat (450) @(posedge clk_i);
    chk(core_reset_o, 1'b1);
    hw_reset_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    chk(core_reset_o, 1'b0);
    rd(OFS_SETUP, RST_SETUP);
    rd(OFS_IMR, RST_IMR);
    settle;
    chk(rd_q.size(), 0);
    give_verdict;
  end
endmodule

bind tbnrd_core tbnrd_core_chk chk_u (.clk_i(clk_i), .rstn_i(rstn_i), .hw_reset_i(hw_reset_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .core_reset_o(core_reset_o),
  .core_run_o(core_run_o), .join_en_o(join_en_o), .tx_drive_o(tx_drive_o),
  .xmit_abort_o(xmit_abort_o), .ram_we_o(ram_we_o), .ram_addr_o(ram_addr_o),
  .ram_data_o(ram_data_o));
